/* core/emif_strobe_cfg.svh */
// Offsets, field positions, codes and counts for the strap/clock/strobe
// block. Assumes a plain register port with an 8-bit byte address.
`ifndef EMIF_STROBE_CFG_SVH
`define EMIF_STROBE_CFG_SVH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_ACC_ADDR   8'h04
`define REG_ACC_CMD    8'h08
`define REG_STATUS     8'h0c

// Control fields
`define CTRL_RATIO_HI  1
`define CTRL_RATIO_LO  0
`define CTRL_READ_ENABLE_MODE_BIT     2
`define CMD_TYPE_HI    1
`define CMD_TYPE_LO    0
`define CMD_WRITE      2
`define CMD_TYPE_BAD   2'h3

// Divide ratio codes
`define RATIO_1        2'h0
`define RATIO_2        2'h1
`define RATIO_4        2'h2
`define RATIO_BAD      2'h3

// Clock-select strap codes
`define SEL_EXT        2'h0
`define SEL_DIV4       2'h1
`define SEL_DIV6       2'h2

// Strap pin positions on the address bus
`define STRAP_ENDIAN   20
`define STRAP_BOOT_HI  19
`define STRAP_BOOT_LO  18
`define STRAP_WIDE_HI  17
`define STRAP_WIDE_LO  16
`define STRAP_NAR_HI   15
`define STRAP_NAR_LO   14

// CPU clock divisors and high-phase lengths
`define CPU_DIV4       3'h4
`define CPU_DIV6       3'h6
`define CPU_HIGH4      3'h2
`define CPU_HIGH6      3'h3

// Chip-space region held in byte-address bits 31..28, space in 27..26
`define CS_REGION      4'h6
`define CS_REGION_HI   31
`define CS_REGION_LO   28
`define CS_SPACE_HI    27
`define CS_SPACE_LO    26
`define CS_FIFO        2'h3

`endif

/* core/emif_strobe_pkg.sv */
// Types shared by the strap/clock/strobe block.
// Assumes the cfg header supplies all numeric codes.
package emif_strobe_pkg;
   // Memory protocol of one access
   typedef enum logic [1:0] {
      MEM_ASYNC,
      MEM_SDRAM,
      MEM_SYNC
   } mem_type_e;
   // Access sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } access_state_e;
endpackage

/* core/clk_ratio_divider.sv */
// Divides the interface clock level by 1, 2 or 4.
// Assumes rise_tick_in marks each rising edge of full_lvl_in.
`timescale 1ns/1ps
`include "emif_strobe_cfg.svh"
module clk_ratio_divider (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       reset_n_in,
   // Interface clock
   input  wire logic       full_lvl_in,
   input  wire logic       rise_tick_in,
   // Requested ratio code
   input  wire logic [1:0] ratio_in,
   // Divided level
   output logic            div_lvl_out
);
   logic [1:0] act_ff;   // Ratio in force
   logic       cnt_ff;   // Rising edges within one half period
   logic       lvl_ff;   // Divided level for ratios 2 and 4
   logic       last;     // Last count of a half period

   // Ratio 4 needs two rising edges per half period
   assign last = (act_ff == `RATIO_4);

   // New ratio only taken as the divided level rises; every old and new
   // ratio has a rising edge at that tick, so no runt pulse
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         act_ff <= `RATIO_1;
         cnt_ff <= 1'b0;
         lvl_ff <= 1'b0;
      end else if (rise_tick_in) begin
         if (cnt_ff == last) begin
            cnt_ff <= 1'b0;
            lvl_ff <= ~lvl_ff;
            if (!lvl_ff) begin
               act_ff <= ratio_in;
            end
         end else begin
            cnt_ff <= 1'b1;
         end
      end
   end

   // Ratio 1 passes the interface clock straight through
   assign div_lvl_out = (act_ff == `RATIO_1) ? full_lvl_in : lvl_ff;
endmodule

/* core/strobe_select.sv */
// Maps sequencer phase onto the shared active-low strobe pins.
// Assumes the caller registers all outputs.
`timescale 1ns/1ps
module strobe_select (
   // Access description
   input  wire emif_strobe_pkg::mem_type_e mem_type_in,
   input  wire logic                       write_in,
   input  wire logic                       read_enable_mode_bit_in,
   input  wire logic                       fifo_space_in,
   // Phase
   input  wire logic                       setup_in,
   input  wire logic                       strobe_in,
   // Pin levels, active low
   output logic                            read_n_out,
   output logic                            oe_n_out,
   output logic                            we_n_out,
   output logic                            fifo_oe_n_out
);
   // One pin, three meanings, chosen by the memory type
   always_comb begin
      read_n_out    = 1'b1;
      oe_n_out      = 1'b1;
      we_n_out      = 1'b1;
      fifo_oe_n_out = 1'b1;
      case (mem_type_in)
         emif_strobe_pkg::MEM_ASYNC: begin
            // Read enable plus output enable, or write enable
            read_n_out = !(strobe_in && !write_in);
            oe_n_out   = !(strobe_in && !write_in);
            we_n_out   = !(strobe_in && write_in);
         end
         emif_strobe_pkg::MEM_SDRAM: begin
            // Row strobe in setup, column strobe after it
            oe_n_out   = !setup_in;
            read_n_out = !strobe_in;
            we_n_out   = !(strobe_in && write_in);
         end
         emif_strobe_pkg::MEM_SYNC: begin
            if (read_enable_mode_bit_in) begin
               // Read enable only on reads
               read_n_out = !(strobe_in && !write_in);
            end else begin
               // Address strobe on every access
               read_n_out = !strobe_in;
            end
            oe_n_out      = !(strobe_in && !write_in);
            we_n_out      = !(strobe_in && write_in);
            fifo_oe_n_out = !(strobe_in && !write_in && fifo_space_in);
         end
         default: begin
            read_n_out = 1'b1;
         end
      endcase
   end
endmodule

/* core/narrow_emif_strap_clock_strobe.sv */
// Strap capture, interface clock selection and shared strobe pins of
// the narrow memory interface. Assumes all pins are synchronous to
// clk_in, which stands for the CPU clock; software starts accesses
// through the register port.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "emif_strobe_cfg.svh"

module narrow_emif_strap_clock_strobe #(
   parameter int ADDR_W = 20 // Address pins, numbered 1..ADDR_W
) (
   // Clock and reset
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   // Register port
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [31:0]       reg_wdata_in,
   input  wire logic              reg_write_in,
   input  wire logic              reg_read_in,
   output logic      [31:0]       reg_rdata_out,
   // Clocks
   input  wire logic              narrow_ext_input_clock_in,
   output logic                   full_rate_output_clock_out,
   output logic                   divided_output_clock_out,
   // Address pins, three signals each
   input  wire logic [ADDR_W:1]   narrow_address_in,
   output logic      [ADDR_W:1]   narrow_address_out,
   output logic                   narrow_address_oe_n_out,
   // Shared strobes and selects, active low
   output logic                   shared_read_strobe_pin_n_out,
   output logic                   shared_output_enable_pin_n_out,
   output logic                   shared_write_pin_n_out,
   output logic                   fifo_output_enable_n_out,
   output logic      [3:0]        chip_space_select_n_out,
   input  wire logic              async_ready_input_in,
   // Captured modes
   output logic                   little_endian_out,
   output logic      [1:0]        boot_mode_out,
   output logic      [1:0]        wide_clock_source_select_out,
   output logic      [1:0]        narrow_clock_source_select_out
);
   // Strap positions assume exactly twenty address pins
   if (ADDR_W != 20) begin : g_bad_width
      $error("ADDR_W must be 20");
   end

   // Chip-space hit for one space, used by selects and FIFO enable
   function automatic logic space_hit(input logic [31:0] addr,
                                      input logic [1:0]  space);
      space_hit = (addr[`CS_REGION_HI:`CS_REGION_LO] == `CS_REGION) &&
                  (addr[`CS_SPACE_HI:`CS_SPACE_LO] == space);
   endfunction

   emif_strobe_pkg::mem_type_e     mem_type_ff;  // Type of current access
   emif_strobe_pkg::access_state_e state_ff;     // Sequencer state
   logic [2:0]  phase_ff;      // CPU clock divider phase
   logic [2:0]  phase_limit;   // Divider length for the strap
   logic        ext_ff;        // Sampled external clock
   logic        src_lvl;       // Selected interface clock level
   logic        rise_tick;     // One cycle per interface rising edge
   logic        div_lvl;       // Divided level from the divider
   logic [1:0]  ratio_ff;      // Requested divide ratio
   logic        read_enable_mode_bit_ff;      // Read-enable mode for sync accesses
   logic [31:0] acc_addr_ff;   // Byte address of the access
   logic        acc_write_ff;  // Access is a write
   logic        pending_ff;    // Command waiting for the sequencer
   logic        ready_ff;      // Sampled ready input
   logic        cmd_go;        // Accepted command write
   logic        busy;          // Access pending or in flight
   logic        rd_n;          // Strobe levels before registering
   logic        oe_n;
   logic        we_n;
   logic        fifo_oe_n;
   logic [31:0] status_word;   // Status register contents

   // Straps follow the pins for every reset cycle; last one is kept
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         // Board must hold these steady for the whole reset
         little_endian_out <= narrow_address_in[`STRAP_ENDIAN];
         boot_mode_out <=
            narrow_address_in[`STRAP_BOOT_HI:`STRAP_BOOT_LO];
         wide_clock_source_select_out <=
            narrow_address_in[`STRAP_WIDE_HI:`STRAP_WIDE_LO];
         narrow_clock_source_select_out <=
            narrow_address_in[`STRAP_NAR_HI:`STRAP_NAR_LO];
      end
   end

   // Address pins are inputs in reset, driven from then on
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         narrow_address_oe_n_out <= 1'b1;
         narrow_address_out      <= '0;
      end else begin
         narrow_address_oe_n_out <= 1'b0;
         // Half-word address: byte address bit 0 is dropped
         narrow_address_out      <= acc_addr_ff[ADDR_W:1];
      end
   end

   // Divider length set by the strap only; reserved code runs external
   always_comb begin
      case (narrow_clock_source_select_out)
         `SEL_DIV6: phase_limit = `CPU_DIV6;
         default:   phase_limit = `CPU_DIV4;
      endcase
   end

   // CPU clock divider phase
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || phase_ff == phase_limit - 3'h1) begin
         phase_ff <= 3'h0;
      end else begin
         phase_ff <= phase_ff + 3'h1;
      end
   end

   // External clock sample; inputs are synchronous to clk_in
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ext_ff <= 1'b0;
      end else begin
         ext_ff <= narrow_ext_input_clock_in;
      end
   end

   // Source is fixed by the captured strap, never by software
   always_comb begin
      case (narrow_clock_source_select_out)
         `SEL_DIV4: src_lvl = (phase_ff < `CPU_HIGH4);
         `SEL_DIV6: src_lvl = (phase_ff < `CPU_HIGH6);
         default:   src_lvl = ext_ff;
      endcase
   end

   // Full-rate clock: the interface clock itself
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         full_rate_output_clock_out <= 1'b0;
      end else begin
         full_rate_output_clock_out <= src_lvl;
      end
   end

   assign rise_tick = src_lvl && !full_rate_output_clock_out;

   clk_ratio_divider u_div (
      .clk_in       (clk_in),
      .reset_n_in   (reset_n_in),
      .full_lvl_in  (src_lvl),
      .rise_tick_in (rise_tick),
      .ratio_in     (ratio_ff),
      .div_lvl_out  (div_lvl)
   );

   // Divided clock, registered like every other pin
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         divided_output_clock_out <= 1'b0;
      end else begin
         divided_output_clock_out <= div_lvl;
      end
   end

   // Software-written control and access address
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ratio_ff    <= `RATIO_1;
         read_enable_mode_bit_ff    <= 1'b0;
         acc_addr_ff <= '0;
      end else if (reg_write_in) begin
         case (reg_addr_in)
            `REG_CTRL: begin
               // Reserved ratio code leaves the ratio alone
               if (reg_wdata_in[`CTRL_RATIO_HI:`CTRL_RATIO_LO] !=
                   `RATIO_BAD) begin
                  ratio_ff <= reg_wdata_in[`CTRL_RATIO_HI:`CTRL_RATIO_LO];
               end
               read_enable_mode_bit_ff <= reg_wdata_in[`CTRL_READ_ENABLE_MODE_BIT];
            end
            `REG_ACC_ADDR: begin
               // Write ignored while an access is pending or in flight
               if (!busy) begin
                  acc_addr_ff <= reg_wdata_in;
               end
            end
            default: begin
               acc_addr_ff <= acc_addr_ff;
            end
         endcase
      end
   end

   // Command accepted only when idle with a legal memory type
   assign busy   = pending_ff || (state_ff != emif_strobe_pkg::ST_IDLE);
   assign cmd_go = reg_write_in && (reg_addr_in == `REG_ACC_CMD) && !busy &&
      (reg_wdata_in[`CMD_TYPE_HI:`CMD_TYPE_LO] != `CMD_TYPE_BAD);

   // Command latch; cleared when the sequencer picks it up
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pending_ff   <= 1'b0;
         mem_type_ff  <= emif_strobe_pkg::MEM_ASYNC;
         acc_write_ff <= 1'b0;
      end else if (cmd_go) begin
         pending_ff   <= 1'b1;
         mem_type_ff  <= emif_strobe_pkg::mem_type_e'(
            reg_wdata_in[`CMD_TYPE_HI:`CMD_TYPE_LO]);
         acc_write_ff <= reg_wdata_in[`CMD_WRITE];
      end else if (rise_tick && state_ff == emif_strobe_pkg::ST_IDLE) begin
         pending_ff   <= 1'b0;
      end
   end

   // Ready is sampled every cycle, used by the sequencer only in async strobes and shown in status
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         ready_ff <= 1'b1;
      end else begin
         ready_ff <= async_ready_input_in;
      end
   end

   // Access sequencer, one step per interface rising edge
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         state_ff <= emif_strobe_pkg::ST_IDLE;
      end else if (rise_tick) begin
         case (state_ff)
            emif_strobe_pkg::ST_IDLE: begin
               if (pending_ff) begin
                  state_ff <= emif_strobe_pkg::ST_SETUP;
               end
            end
            emif_strobe_pkg::ST_SETUP: begin
               state_ff <= emif_strobe_pkg::ST_STROBE;
            end
            emif_strobe_pkg::ST_STROBE: begin
               // Slow async device stretches the strobe
               if (mem_type_ff != emif_strobe_pkg::MEM_ASYNC || ready_ff) begin
                  state_ff <= emif_strobe_pkg::ST_HOLD;
               end
            end
            default: begin
               state_ff <= emif_strobe_pkg::ST_IDLE;
            end
         endcase
      end
   end

   strobe_select u_strobe (
      .mem_type_in   (mem_type_ff),
      .write_in      (acc_write_ff),
      .read_enable_mode_bit_in      (read_enable_mode_bit_ff),
      .fifo_space_in (space_hit(acc_addr_ff, `CS_FIFO)),
      .setup_in      (state_ff == emif_strobe_pkg::ST_SETUP),
      .strobe_in     (state_ff == emif_strobe_pkg::ST_STROBE),
      .read_n_out    (rd_n),
      .oe_n_out      (oe_n),
      .we_n_out      (we_n),
      .fifo_oe_n_out (fifo_oe_n)
   );

   // Strobe pins registered; all high in reset
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         shared_read_strobe_pin_n_out   <= 1'b1;
         shared_output_enable_pin_n_out <= 1'b1;
         shared_write_pin_n_out         <= 1'b1;
         fifo_output_enable_n_out       <= 1'b1;
      end else begin
         shared_read_strobe_pin_n_out   <= rd_n;
         shared_output_enable_pin_n_out <= oe_n;
         shared_write_pin_n_out         <= we_n;
         fifo_output_enable_n_out       <= fifo_oe_n;
      end
   end

   // One select per space; the decode makes them mutually exclusive
   for (genvar i = 0; i < 4; i++) begin : g_cs
      always_ff @(posedge clk_in) begin
         if (!reset_n_in) begin
            chip_space_select_n_out[i] <= 1'b1;
         end else begin
            chip_space_select_n_out[i] <=
               !((state_ff != emif_strobe_pkg::ST_IDLE) &&
                 space_hit(acc_addr_ff, 2'(i)));
         end
      end
   end

   // Status view of captured straps and sequencer
   assign status_word = {23'h0, ready_ff, narrow_clock_source_select_out,
                         wide_clock_source_select_out, boot_mode_out,
                         little_endian_out, busy};

   // Read data stand for exactly the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (!reset_n_in || !reg_read_in) begin
         reg_rdata_out <= 32'h0;
      end else begin
         case (reg_addr_in)
            `REG_CTRL:     reg_rdata_out <= {29'h0, read_enable_mode_bit_ff, ratio_ff};
            `REG_ACC_ADDR: reg_rdata_out <= acc_addr_ff;
            `REG_STATUS:   reg_rdata_out <= status_word;
            default:       reg_rdata_out <= 32'h0;
         endcase
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_gap4;
      ##1 !rise_tick [*3] ##1 rise_tick;
   endsequence
   sequence s_gap6;
      ##1 !rise_tick [*5] ##1 rise_tick;
   endsequence

   property p_div4_period;
      (narrow_clock_source_select_out == `SEL_DIV4 && rise_tick) |-> s_gap4;
   endproperty
   a_div4_period: assert property (p_div4_period)
      else $error("div4 interface clock period wrong");

   property p_div6_period;
      (narrow_clock_source_select_out == `SEL_DIV6 && rise_tick) |-> s_gap6;
   endproperty
   a_div6_period: assert property (p_div6_period)
      else $error("div6 interface clock period wrong");

   property p_ext_follow;
      (narrow_clock_source_select_out == `SEL_EXT && $past(reset_n_in, 2))
         |-> full_rate_output_clock_out ==
             $past(narrow_ext_input_clock_in, 2);
   endproperty
   a_ext_follow: assert property (p_ext_follow)
      else $error("full-rate clock does not follow external clock");

   property p_strap_hold;
      $past(reset_n_in) |-> $stable(narrow_clock_source_select_out) &&
         $stable(boot_mode_out) && $stable(little_endian_out);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("strap changed after reset");

   property p_addr_input_reset;
      $rose(reset_n_in) |-> narrow_address_oe_n_out ##1
         !narrow_address_oe_n_out;
   endproperty
   a_addr_input_reset: assert property (p_addr_input_reset)
      else $error("address pins not released from reset correctly");

   property p_ready_stretch;
      (state_ff == emif_strobe_pkg::ST_STROBE && rise_tick && !ready_ff &&
       mem_type_ff == emif_strobe_pkg::MEM_ASYNC)
         |=> state_ff == emif_strobe_pkg::ST_STROBE;
   endproperty
   a_ready_stretch: assert property (p_ready_stretch)
      else $error("async strobe ended while ready low");

   property p_one_select;
      $onehot0(~chip_space_select_n_out);
   endproperty
   a_one_select: assert property (p_one_select)
      else $error("more than one chip select active");

   property p_fifo_space3;
      !fifo_output_enable_n_out |-> !chip_space_select_n_out[3];
   endproperty
   a_fifo_space3: assert property (p_fifo_space3)
      else $error("FIFO output enable outside space 3");

   property p_sdram_ras;
      (state_ff == emif_strobe_pkg::ST_SETUP &&
       mem_type_ff == emif_strobe_pkg::MEM_SDRAM)
         |=> !shared_output_enable_pin_n_out && shared_read_strobe_pin_n_out;
   endproperty
   a_sdram_ras: assert property (p_sdram_ras)
      else $error("SDRAM row strobe missing in setup");

   property p_sync_ads;
      (state_ff == emif_strobe_pkg::ST_STROBE && !read_enable_mode_bit_ff &&
       mem_type_ff == emif_strobe_pkg::MEM_SYNC)
         |=> !shared_read_strobe_pin_n_out;
   endproperty
   a_sync_ads: assert property (p_sync_ads)
      else $error("sync address strobe missing");
endmodule

/* verification/ext_mem_model.sv */
// Board and async memory stand-in: strap pulls, released pins, ready.
// Assumes strobes are active low and synchronous to clk_in.
`timescale 1ns/1ps
module ext_mem_model (
   // Clock
   input  wire logic        clk_in,
   // Device side
   input  wire logic [20:1] addr_in,
   input  wire logic        addr_oe_n_in,
   input  wire logic        strobe_n_in,
   // Board settings
   input  wire logic [6:0]  strap_in,
   input  wire logic [7:0]  wait_in,
   // Pin levels seen by the device
   output logic      [20:1] pins_out,
   output logic             ready_out
);
   logic [7:0] cnt_ff; // Cycles since strobe fell
   // Released pins show only the pulls, never the last address
   assign pins_out = addr_oe_n_in ? {strap_in, 13'h0} : addr_in;
   // Slow memory: ready held low for wait_in cycles of a strobe
   always_ff @(posedge clk_in) begin
      cnt_ff <= strobe_n_in ? 8'h0 : cnt_ff + 8'h1;
   end
   assign ready_out = strobe_n_in | (cnt_ff >= wait_in);
endmodule

/* verification/tb_top.sv */
// Register-driven bench for strap capture, clocks and shared strobes.
// Assumes the cfg header map and ext_mem_model on the pins.
`timescale 1ns/1ps
`include "emif_strobe_cfg.svh"
module tb_top;
   logic        clk_in, reset_n_in, wr_s, rd_s, rdy, clr, full, dv, aoe_n;
   logic        rd_n, oe_n, we_n, ff_n, le;
   logic [7:0]  ra, wt;
   logic [31:0] wd, rdat, v;
   logic [20:1] pins, ao, a_seen;
   logic [6:0]  strap;
   logic [3:0]  cs_n, cs_seen, lo_seen;
   logic [1:0]  boot, ws, ns;
   logic [2:0]  ec = 3'h0; // External clock divider, period 8 clk
   int          num_errors, samples_checked, n, n2, rd_low;
   // Reserved narrow select 11 runs from the external clock
   logic [6:0]  s_tab [4] = '{7'b1100000, 7'b0101011, 7'b0000110,
      7'b1011001};
   int          p_tab [4] = '{8, 4, 6, 8};
   // {read_enable_mode_bit, type, write, space, seen low rd/oe/we/fifo}
   logic [9:0]  a_tab [8] = '{10'b0000011100, 10'b0001100010,
      10'b0010001100, 10'b0011001110, 10'b1100111101,
      10'b0101001010, 10'b1101000010, 10'b0100111101};
   narrow_emif_strap_clock_strobe #(.ADDR_W(20))
      narrow_emif_strap_clock_strobe_i (.clk_in(clk_in),
      .reset_n_in(reset_n_in), .reg_addr_in(ra), .reg_wdata_in(wd),
      .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdat),
      .narrow_ext_input_clock_in(ec[2]), .full_rate_output_clock_out(full),
      .divided_output_clock_out(dv), .narrow_address_in(pins),
      .narrow_address_out(ao), .narrow_address_oe_n_out(aoe_n),
      .shared_read_strobe_pin_n_out(rd_n),
      .shared_output_enable_pin_n_out(oe_n), .shared_write_pin_n_out(we_n),
      .fifo_output_enable_n_out(ff_n), .chip_space_select_n_out(cs_n),
      .async_ready_input_in(rdy), .little_endian_out(le),
      .boot_mode_out(boot), .wide_clock_source_select_out(ws),
      .narrow_clock_source_select_out(ns));
   ext_mem_model ext_mem_model_i (.clk_in(clk_in), .addr_in(ao),
      .addr_oe_n_in(aoe_n), .strobe_n_in(rd_n & we_n), .strap_in(strap),
      .wait_in(wt), .pins_out(pins), .ready_out(rdy));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // Pin monitor: which strobes fell, selects and address seen
   always @(posedge clk_in) begin
      ec <= ec + 3'h1;
      lo_seen <= clr ? 4'h0 : lo_seen | ~{rd_n, oe_n, we_n, ff_n};
      cs_seen <= clr ? 4'hf : cs_seen & cs_n;
      rd_low <= clr ? 0 : rd_low + int'(!rd_n);
      if (clr) a_seen <= '0;
      else if (cs_n != 4'hf) a_seen <= ao;
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ra <= a; wd <= d; wr_s <= 1'b1;
      @(posedge clk_in); wr_s <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      ra <= a; rd_s <= 1'b1;
      @(posedge clk_in); rd_s <= 1'b0;
      #1 d = rdat;
      @(posedge clk_in);
   endtask
   // Rising-edge to rising-edge period of an output clock, in clk cycles
   task automatic per(input bit d, output int c);
      int k;
      logic p, s;
      k = -1; c = 0; p = 1'b1;
      repeat (200) begin
         @(posedge clk_in); #1 s = d ? dv : full;
         if (k >= 0) k++;
         if (s && !p) begin
            if (k > 0) break;
            k = 0;
         end
         p = s;
      end
      c = k;
      @(posedge clk_in);
   endtask
   task automatic acc(input logic [9:0] t);
      logic [31:0] a;
      a = {4'h6, t[5:4], 26'h2b4c6a};
      wr(`REG_CTRL, {29'h0, t[9], 2'h0});
      clr <= 1'b1; @(posedge clk_in); clr <= 1'b0;
      wr(`REG_ACC_ADDR, a);
      wr(`REG_ACC_CMD, {29'h0, t[6], t[8:7]});
      repeat (200) begin rd(`REG_STATUS, v); if (!v[0]) break; end
      chk("idle", 0, v[0]);
      chk("strobes", t[3:0], lo_seen);
      chk("cs", 4'(~(4'h1 << t[5:4])), cs_seen);
      chk("addr", a[20:1], a_seen);
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {wr_s, rd_s, clr, reset_n_in, ra, wd, wt} = '0;
      {num_errors, samples_checked, strap} = '0;
      foreach (s_tab[i]) begin
         reset_n_in <= 1'b0; strap <= s_tab[i];
         repeat (9) @(posedge clk_in);
         #1 chk("oe_n rst", 1, aoe_n);
         @(posedge clk_in); reset_n_in <= 1'b1; strap <= ~s_tab[i];
         repeat (3) @(posedge clk_in);
         #1 chk("oe_n run", 0, aoe_n);
         chk("straps", s_tab[i], {le, boot, ws, ns});
         @(posedge clk_in);
         rd(`REG_STATUS, v);
         chk("status", s_tab[i], {v[1], v[3:2], v[5:4], v[7:6]});
         per(0, n);
         chk("full per", p_tab[s_tab[i][1:0]], n);
      end
      for (int r = 0; r < 4; r++) begin
         wr(`REG_CTRL, r);
         per(1, n); per(1, n);
         chk("div per", 4 << (r == 3 ? 2 : r), n);
      end
      rd(8'h10, v);
      chk("unmapped", 0, v);
      foreach (a_tab[i]) acc(a_tab[i]);
      n2 = rd_low;
      wt <= 8'h1e; acc(a_tab[0]);
      chk("stretch", 1, rd_low >= 30 && n2 < 30);
      give_verdict;
   end
   initial begin
      #2000000;
      num_errors++;
      give_verdict;
   end
endmodule
